// *** rtl/swb_core.v ***
// single-wire serial status, data low register and push/pull sequencer
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
module swb_core (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata_ff,
  // status two setup inputs (status two is read only)
  input wire stop_in_wait,
  input wire single_wire_mode_enable,
  input wire receive_delay_sel_hi,
  input wire receive_delay_sel_lo,
  // link pins
  input wire receive_pin,
  output reg transmit_pin_ff,
  // interrupt
  output wire irq
);
`include "swb_regs.vh"

  // ==================================================
  // states
  localparam ST_IDLE = 2'h0;
  localparam ST_PUSH = 2'h1;
  localparam ST_DELAY = 2'h2;
  localparam ST_PULL = 2'h3;
  // last bit index of each field, cut to the bit counter's width where used
  localparam integer PUSH_LAST = `SWB_PUSH_BITS - 1;
  localparam integer PULL_LAST = `SWB_PULL_BITS - 1;

  reg [2:0] rx_sync_ff;
  reg rx_clean_ff;
  reg [1:0] state_ff;
  reg [7:0] tx_ff;
  reg [7:0] rx_data_ff;
  reg [7:0] shift_ff;
  reg [3:0] bit_ff;
  reg [3:0] sub_ff;
  reg sample_a_ff;
  reg err_ff;
  reg [7:0] status_one_ff;
  reg [7:0] seen_ff;
  reg [7:0] mask_ff;
  reg [3:0] control_ff;
  reg rx_active_ff;
  wire tick;
  wire [1:0] delay_sel;
  wire [7:0] status_two;

  // tick generator halts in wait when stop_in_wait is set
  swb_tick_gen u_tick (
    .clk(clk),
    .resetn(resetn),
    .halt(stop_in_wait & control_ff[`SWB_CT_WAIT]), // [RL4]
    .tick_ff(tick)
  );

  assign delay_sel = {receive_delay_sel_hi, receive_delay_sel_lo};
  // reserved bits 3..1 tied low
  assign status_two = {stop_in_wait, single_wire_mode_enable, delay_sel, 3'b000, rx_active_ff}; // [RL18]

  // ==================================================
  // receive pin synchroniser: change accepted when stages two and three agree
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_sync_ff <= 3'b111;
      rx_clean_ff <= 1'b1;
    end
    else
    begin
      rx_sync_ff <= {rx_sync_ff[1:0], receive_pin};
      if (rx_sync_ff[1] == rx_sync_ff[2])
        rx_clean_ff <= rx_sync_ff[2];
    end
  end

  // ==================================================
  // sequencer: push field (8 bits, 16 ticks each), delay, pull field (3 bits)
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      bit_ff <= 4'h0;
      sub_ff <= 4'h0;
      sample_a_ff <= 1'b1;
      err_ff <= 1'b0;
      transmit_pin_ff <= 1'b1;
      rx_active_ff <= 1'b0;
      rx_data_ff <= `SWB_RX_ERROR;
    end
    else if (!single_wire_mode_enable)
    begin
      // plain serial mode: this sequencer stays parked, pin recessive
      state_ff <= ST_IDLE; // [RL5]
      transmit_pin_ff <= 1'b1;
      rx_active_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          transmit_pin_ff <= 1'b1;
          bit_ff <= 4'h0;
          sub_ff <= 4'h0;
          err_ff <= 1'b0;
          if (control_ff[`SWB_CT_TX_GO])
          begin
            // data bits 4..0 go first, lsb first, then address 7..5
            shift_ff <= tx_ff; // [RL13]
            state_ff <= ST_PUSH;
          end
          else if (control_ff[`SWB_CT_PULL_GO] && control_ff[`SWB_CT_RX_EN])
          begin
            // only a pull sync may start reception
            state_ff <= ST_DELAY; // [RL16]
            rx_active_ff <= 1'b1; // [RL7]
          end
        end
        ST_PUSH:
        begin
          transmit_pin_ff <= shift_ff[0];
          if (tick)
          begin
            sub_ff <= sub_ff + 4'h1;
            if (sub_ff == 4'h8)
              err_ff <= err_ff | (rx_clean_ff != shift_ff[0]); // [RL17]
            if (sub_ff == 4'hF)
            begin
              shift_ff <= {1'b0, shift_ff[7:1]};
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == PUSH_LAST[3:0])
                state_ff <= ST_IDLE;
            end
          end
        end
        ST_DELAY:
        begin
          // wait delay factor sixteenths of a slot before sampling
          if (tick)
          begin
            sub_ff <= sub_ff + 4'h1;
            if (sub_ff == {2'b00, delay_sel})
            begin
              sub_ff <= 4'h0;
              state_ff <= ST_PULL; // [RL6]
            end
          end
        end
        default:
        begin
          if (tick)
          begin
            sub_ff <= sub_ff + 4'h1;
            if (sub_ff == 4'h4)
              sample_a_ff <= rx_clean_ff;
            if (sub_ff == 4'h8)
            begin
              if (sample_a_ff != rx_clean_ff)
                err_ff <= 1'b1;
              // shifted in from the top: first arrival ends in bit 5, read out in bit 3
              shift_ff <= {rx_clean_ff, shift_ff[7:1]}; // [RL11]
            end
            if (sub_ff == 4'hF)
            begin
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff == PULL_LAST[3:0])
              begin
                state_ff <= ST_IDLE;
                rx_active_ff <= 1'b0; // [RL7]
                rx_data_ff <= err_ff ? `SWB_RX_ERROR : // [RL10]
                  {`SWB_PULL_HEAD, shift_ff[5], shift_ff[6], shift_ff[7], 1'b1}; // [RL9] [RL11]
              end
            end
          end
        end
      endcase
    end
  end

  // ==================================================
  // events, status one, interrupt; set wins over clear
  wire ev_bit_err = (state_ff == ST_PUSH) && tick && (sub_ff == 4'h8) && (rx_clean_ff != shift_ff[0]); // [RL1]
  wire ev_noise = (state_ff == ST_PULL) && tick && (sub_ff == 4'h8) && (sample_a_ff != rx_clean_ff); // [RL3]
  wire ev_full = (state_ff == ST_PULL) && tick && (sub_ff == 4'hF) && (bit_ff == PULL_LAST[3:0]);
  wire rd_s1 = rd && (addr == `SWB_OFF_STATUS_ONE);
  wire rd_dl = rd && (addr == `SWB_OFF_DATA_LOW);
  wire [7:0] ev_vec = ({7'h00, ev_full} << `SWB_S1_FULL) | ({7'h00, ev_bit_err} << `SWB_S1_BIT_ERR)
    | ({7'h00, ev_noise} << `SWB_S1_NOISE);
  wire [7:0] irq_mask_eff = single_wire_mode_enable ? (mask_ff & ~(8'h01 << `SWB_S1_BIT_ERR)) : mask_ff; // [RL2]
  assign irq = |(status_one_ff & irq_mask_eff);

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      status_one_ff <= 8'h00;
      seen_ff <= 8'h00;
    end
    else
    begin
      if (rd_s1)
        seen_ff <= status_one_ff;
      else if (rd_dl)
        seen_ff <= 8'h00;
      // only flags seen at the status read are cleared by the data read
      status_one_ff <= (status_one_ff & ~(rd_dl ? seen_ff : 8'h00)) | ev_vec; // [RL15]
    end
  end

  // ==================================================
  // writable registers: transmit, control, mask
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_ff <= 8'h00;
      control_ff <= 4'h0;
      mask_ff <= 8'h00;
    end
    else
    begin
      // go bits are self clearing
      control_ff[`SWB_CT_TX_GO] <= 1'b0;
      control_ff[`SWB_CT_PULL_GO] <= 1'b0;
      if (wr)
      begin
        case (addr)
          `SWB_OFF_DATA_LOW: tx_ff <= wdata; // [RL12] [RL14]
          `SWB_OFF_CONTROL: control_ff <= wdata[3:0];
          `SWB_OFF_IRQ_MASK: mask_ff <= wdata;
          default: ; // status registers ignore writes [RL8]
        endcase
      end
    end
  end

  // ==================================================
  // read data, one cycle after the strobe
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_ff <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `SWB_OFF_STATUS_ONE: rdata_ff <= status_one_ff;
        `SWB_OFF_STATUS_TWO: rdata_ff <= status_two; // [RL8]
        `SWB_OFF_DATA_LOW: rdata_ff <= rx_data_ff; // [RL12]
        `SWB_OFF_CONTROL: rdata_ff <= {4'h0, control_ff};
        `SWB_OFF_IRQ_MASK: rdata_ff <= mask_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
    else
      rdata_ff <= 8'h00;
  end
endmodule

// *** common/swb_regs.vh ***
// register offsets, field positions, reset values and timing counts for the single-wire serial block
// Notes on behaviour
// RL1: bit error flag sets when a push bit read back differs from the bit sent
// RL2: bit error flag never raises an interrupt while single-wire mode is on
// RL3: noise flag sets when the two receive samples disagree during a pull field
// RL4: stop_in_wait set halts the serial clock while the chip waits
// RL5: single_wire_mode_enable switches block between single-wire bus and plain serial behaviour; here mode off only parks the sequencer with the pin high
// RL6: two-bit delay select sets receive start delay of 1 to 4 sixteenths of a slot
// RL7: receiver_active_flag is one exactly while a character is being received
// RL8: writes to status two change nothing; reads allowed at any time
// RL9: valid pull field reads as 0101 then three status bits then one
// RL10: an error during the pull field makes receive data read all ones
// RL11: pull bits shift in lsb first; status bits land in bits 3, 2, 1
// RL12: data low reads the receive register, writes load a separate transmit register
// RL13: push field sends five data bits then three address bits
// RL14: software puts data in bits 4 to 0 and address in 7 to 5 first
// RL15: receive flags clear on status-one read then data-low read, only those seen set
// RL16: reception starts only on pull sync and stays off during a push field
// RL17: receive pin is compared with the sent bit at every push bit time
// RL18: bits 3 to 1 of status two always read zero
`ifndef SWB_REGS_VH
`define SWB_REGS_VH

// ==================================================
// register offsets
`define SWB_OFF_STATUS_ONE 8'hC4
`define SWB_OFF_STATUS_TWO 8'hC5
`define SWB_OFF_DATA_LOW 8'hC7
`define SWB_OFF_CONTROL 8'hC8
`define SWB_OFF_IRQ_MASK 8'hC9

// ==================================================
// status two fields
`define SWB_S2_STOP_IN_WAIT 7
`define SWB_S2_MODE_EN 6
`define SWB_S2_DELAY_HI 5
`define SWB_S2_DELAY_LO 4
`define SWB_S2_RX_ACTIVE 0
`define SWB_S2_RESET 8'h00

// ==================================================
// status one fields (event bits, also the irq mask layout)
`define SWB_S1_FULL 5
`define SWB_S1_BIT_ERR 3
`define SWB_S1_NOISE 2

// ==================================================
// control fields
`define SWB_CT_RX_EN 0
`define SWB_CT_TX_GO 1
`define SWB_CT_PULL_GO 2
`define SWB_CT_WAIT 3

// ==================================================
// receive data patterns
`define SWB_PULL_HEAD 4'h5
`define SWB_RX_ERROR 8'hFF

// ==================================================
// timing: clock 50 ns, time slot 25 us
`define SWB_CLK_NS 50
`define SWB_SLOT_NS 25000
`define SWB_SLOT_CYC (`SWB_SLOT_NS / `SWB_CLK_NS)
`define SWB_TICK_CYC (`SWB_SLOT_CYC / 16)
`define SWB_PUSH_BITS 8
`define SWB_PULL_BITS 3

`endif

// *** rtl/swb_tick_gen.v ***
// sixteenth-of-slot tick generator with stop-in-wait gating
`timescale 1ns/1ns
module swb_tick_gen (
  // clock and reset
  input wire clk,
  input wire resetn,
  // control
  input wire halt,
  // output
  output reg tick_ff
);
`include "swb_regs.vh"

  // reload value of the down counter; fits the ten-bit counter
  localparam integer TICK_LAST = `SWB_TICK_CYC - 1;

  reg [9:0] cnt_ff;
  wire [9:0] nxt_cnt;

  // count down one sixteenth of a slot; halt freezes the generator
  assign nxt_cnt = (cnt_ff == 10'h000) ? TICK_LAST[9:0] : cnt_ff - 10'h001;

  // ==================================================
  // tick register
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff <= 10'h000;
      tick_ff <= 1'b0;
    end
    else if (halt)
    begin
      tick_ff <= 1'b0; // [RL4]
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= (cnt_ff == 10'h000);
    end
  end
endmodule

// *** bench/swb_chk_assertions.sv ***
// port assertions for the single-wire serial core
`timescale 1ns/1ns
module swb_chk (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata_ff,
  // status two setup
  input wire stop_in_wait,
  input wire single_wire_mode_enable,
  input wire receive_delay_sel_hi,
  input wire receive_delay_sel_lo,
  // link and interrupt
  input wire receive_pin,
  input wire transmit_pin_ff,
  input wire irq
);
  // ==========
  // helpers
  // last byte written for sending, so the first bit out can be judged
  reg [7:0] tx_sh_ff;
  always @(posedge clk or negedge resetn)
    if (!resetn)
      tx_sh_ff <= 8'h00;
    else if (wr && addr == 8'hC7)
      tx_sh_ff <= wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_rd(a);
    rd && addr == a;
  endsequence
  // push start while awake and in single-wire mode
  sequence s_push;
    wr && addr == 8'hC8 && wdata[1] && !wdata[3] && single_wire_mode_enable;
  endsequence
  // ==========
  // assertions
  chk_rd_idle: assert property (!$past(rd) |-> rdata_ff == 8'h00)
    else $error("read data not zero outside a read");
  chk_s2_fields: assert property (s_rd(8'hC5) |=> rdata_ff[7:4] == {$past(stop_in_wait),
    $past(single_wire_mode_enable), $past(receive_delay_sel_hi), $past(receive_delay_sel_lo)})
    else $error("status two fields wrong");
  chk_s2_zero: assert property (s_rd(8'hC5) |=> rdata_ff[3:1] == 3'h0)
    else $error("status two unused bits set");
  chk_rx_shape: assert property (s_rd(8'hC7) |=> rdata_ff == 8'hFF ||
    (rdata_ff[7:4] == 4'h5 && rdata_ff[0]))
    else $error("receive data shape wrong");
  chk_berr_quiet: assert property (s_rd(8'hC4) ##1 (rdata_ff == 8'h08 && single_wire_mode_enable)
    |-> !irq)
    else $error("bit error raised irq");
  chk_irq_idle: assert property (s_rd(8'hC4) ##1 rdata_ff == 8'h00 |-> !irq)
    else $error("irq without a cause");
  chk_mode_off: assert property (!single_wire_mode_enable [*8] |-> transmit_pin_ff)
    else $error("line driven with mode off");
  // go bit lands, sequencer leaves idle, then the pin shows bit 0
  chk_push_start: assert property (s_push |=> ##2 transmit_pin_ff == tx_sh_ff[0])
    else $error("first push bit wrong");
  chk_bit_hold: assert property ($fell(transmit_pin_ff) |=> !transmit_pin_ff [*8])
    else $error("low bit too short");
endmodule
bind swb_core swb_chk i_swb_chk (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata_ff, .stop_in_wait,
  .single_wire_mode_enable, .receive_delay_sel_hi, .receive_delay_sel_lo, .receive_pin,
  .transmit_pin_ff, .irq);

// *** bench/swb_slave.sv ***
// behavioural slave on the single-wire bus
`timescale 1ns/1ns
`include "swb_regs.vh"
module swb_slave (
  // clock
  input wire clk,
  // bus pins of the core
  input wire tx,
  output wire rx,
  // commands from the bench
  input wire push_go,
  input wire pull_go,
  input wire hold_low,
  input wire noisy,
  input wire [2:0] stat,
  input wire [1:0] dly,
  // captured push byte
  output logic [7:0] got
);
  localparam int BIT = `SWB_TICK_CYC * 16;
  localparam int HALF = `SWB_TICK_CYC * 4;
  logic lvl = 1'b1;
  logic sq = 1'b0;
  logic [7:0] cnt = 8'h00;
  int k;
  int j;
  // pulled-up line, any party pulls low
  assign rx = tx & lvl & ~hold_low & ~(noisy & sq);
  // noise half period equals the spacing of the receiver's two samples, so every pair disagrees while the slave releases the line
  always @(posedge clk)
    if (cnt == 8'(HALF - 1))
    begin
      cnt <= 8'h00;
      sq <= ~sq;
    end
    else
      cnt <= cnt + 8'h01;
  // sample each push bit mid-slot in order of departure
  always @(posedge push_go)
  begin
    repeat (BIT / 2) @(posedge clk);
    for (k = 0; k < 8; k++)
    begin
      got[k] = tx;
      repeat (BIT) @(posedge clk);
    end
  end
  // answer a pull: first status bit goes out first
  always @(posedge pull_go)
  begin
    repeat ((dly + 1) * `SWB_TICK_CYC) @(posedge clk);
    for (j = 2; j >= 0; j--)
    begin
      lvl = stat[j];
      repeat (BIT) @(posedge clk);
    end
    lvl = 1'b1;
  end
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the single-wire serial core
`timescale 1ns/1ns
`include "swb_regs.vh"
module testbench;
  // ==========
  // signals
  localparam int BIT = `SWB_TICK_CYC * 16;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, sw = 0, me = 0, dh = 0, dl = 0;
  logic pu = 0, pl = 0, hl = 0, nz = 0;
  logic [2:0] st = 0;
  logic [7:0] addr = 0, wdata = 0;
  wire [7:0] rdata_ff, got;
  wire rxp, txp, irq;
  int errors = 0, checks = 0, i;
  initial forever #25 clk = ~clk;
  swb_core i_swb_core (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata_ff, .stop_in_wait(sw),
    .single_wire_mode_enable(me), .receive_delay_sel_hi(dh), .receive_delay_sel_lo(dl),
    .receive_pin(rxp), .transmit_pin_ff(txp), .irq);
  swb_slave i_swb_slave (.clk, .tx(txp), .rx(rxp), .push_go(pu), .pull_go(pl), .hold_low(hl),
    .noisy(nz), .stat(st), .dly({dh, dl}), .got);
  // ==========
  // tasks
  task automatic check(input logic [7:0] s, e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, e, m = 8'hFF);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 check(rdata_ff & m, e & m);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========
  // tests
  initial
  begin
    idle(20);
    resetn <= 1;
    rreg(8'hC5, 8'h00);
    rreg(8'h10, 8'h00);
    wreg(8'hC8, 8'h02);
    idle(300);
    #1 check({7'h0, txp}, 8'h01);
    sw <= 1;
    me <= 1;
    dh <= 1;
    dl <= 1;
    wreg(8'hC5, 8'h0F);
    rreg(8'hC5, 8'hF0);
    sw <= 0;
    wreg(8'hC9, 8'h2C);
    wreg(8'hC7, 8'hA6);
    pu <= 1;
    wreg(8'hC8, 8'h02);
    pu <= 0;
    idle(9 * BIT);
    check(got, 8'hA6);
    rreg(8'hC4, 8'h00);
    // slave holds the line low so every sent one reads back wrong
    hl <= 1;
    wreg(8'hC7, 8'hFF);
    wreg(8'hC8, 8'h02);
    idle(9 * BIT);
    hl <= 0;
    #1 check({7'h0, irq}, 8'h00);
    rreg(8'hC4, 8'h08);
    rreg(8'hC7, 8'hFF);
    rreg(8'hC4, 8'h00);
    // pulls at every delay code, full flag masked on the first
    for (i = 0; i < 4; i++)
    begin
      {dh, dl} <= i[1:0];
      st <= 3'(i + 3);
      wreg(8'hC9, i ? 8'h2C : 8'h0C);
      pl <= 1;
      wreg(8'hC8, 8'h05);
      pl <= 0;
      idle(BIT);
      rreg(8'hC5, {2'b01, i[1:0], 4'h1});
      idle(3 * BIT);
      #1 check({7'h0, irq}, {7'h0, i != 0});
      rreg(8'hC4, 8'h20);
      rreg(8'hC7, {4'h5, st, 1'b1});
      rreg(8'hC4, 8'h00);
      rreg(8'hC5, {2'b01, i[1:0], 4'h0});
    end
    nz <= 1;
    pl <= 1;
    wreg(8'hC8, 8'h05);
    pl <= 0;
    idle(4 * BIT);
    nz <= 0;
    rreg(8'hC4, 8'h04, 8'h04);
    rreg(8'hC7, 8'hFF);
    // push in chip wait: first bit must stall until wait ends
    sw <= 1;
    wreg(8'hC7, 8'h01);
    wreg(8'hC8, 8'h0A);
    idle(2 * BIT);
    #1 check({7'h0, txp}, 8'h01);
    wreg(8'hC8, 8'h00);
    idle(3 * BIT / 2);
    #1 check({7'h0, txp}, 8'h00);
    idle(7 * BIT);
    tally_and_finish;
  end
  // watchdog well beyond the expected run
  initial
  begin
    idle(40000);
    errors++;
    tally_and_finish;
  end
endmodule
